// *** design/coc_defines.vh ***
`ifndef COC_DEFINES_VH
`define COC_DEFINES_VH
// Register addresses on the serial control bus.
`define COC_ADDR_DC       8'h20
`define COC_ADDR_CTRL     8'h21
`define COC_ADDR_RAM      8'h22
// Reset values.
`define COC_DC_RST        6'h00
`define COC_CTRL_RST      8'h00
// Field positions.
`define COC_DC_SIGN       5
`define COC_DC_MAG_HI     4
`define COC_CTRL_ECE      4
`define COC_CTRL_CNTR     1
`define COC_CTRL_CAL      0
`define COC_RAM_SIGN      3
`define COC_RAM_MAG_HI    2
// Column store geometry.
`define COC_COLS          704
`define COC_LAST_COL      10'h2BF
`define COC_COL_W         10
`define COC_DARK_ROWS     3'h4
`define COC_DARK_LAST     2'h3
// Clipping of a measured average into a RAM code.
`define COC_CLIP_LIM      10'h00F
`define COC_CODE_NEG_MAX  4'hF
`define COC_CODE_POS_MAX  4'h7
`endif

// *** design/coc_column_offset_calibration.v ***
`timescale 1ns/1ps
`include "coc_defines.vh"
// Behaviour
// - DC offset: sign bit5, magnitude bits4-0, doubled
// - DC offset register resets to zero
// - Control bit4 selects per-column RAM offsets
// - Global offset path active straight after reset
// - Control bit1 returns load counter to zero
// - Control bit0 regenerates RAM from dark measurements
// - Calibration runs automatically after every reset
// - Column offset averages four dark rows
// - Store holds 704 entries of 4 bits
// - RAM-port writes store then advance counter
// - RAM entry: sign bit3, magnitude bits2-0, doubled
// - Offsets expressed in ADC codes, gain two
module coc_column_offset_calibration (
    // Clock and reset.
    input  wire        sys_clk_in,
    input  wire        nrst_in,
    // Register port, already decoded from the serial bus.
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    input  wire [7:0]  reg_addr_in,
    input  wire [7:0]  reg_wdata_in,
    output reg  [7:0]  reg_rdata_out,
    // Dark-row measurement stream from the signal chain.
    input  wire        dark_valid_in,
    input  wire [9:0]  dark_col_in,
    input  wire [7:0]  dark_diff_in,
    // Pixel side: column being read out and offset to apply.
    input  wire [9:0]  pix_col_in,
    output reg  [10:0] col_offset_out,
    output reg         offset_enable_out,
    output reg         cal_busy_out
);

    // Decode a sign-magnitude code into a doubled signed offset in ADC codes.
    // Both the global register and the RAM entries share this coding, so
    // one decoder serves both; a negative zero simply yields zero.
    function [10:0] coc_doubled;
        input       sign;
        input [4:0] mag;
        reg   [10:0] twice;
        begin
            twice = {5'h00, mag, 1'b0};
            coc_doubled = sign ? (11'h000 - twice) : twice;
        end
    endfunction

    // Calibration state machine codes.
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_MEAS = 2'h1;
    localparam [1:0] ST_DONE = 2'h2;
    // Code 2'h3 is never entered; the default branch steers it to idle.

    reg [5:0]            dc_r;        // Global column offset code.
    reg [7:0]            ctrl_r;      // Control register image.
    reg [`COC_COL_W-1:0] ld_col_r;    // RAM load column counter.
    reg [3:0]            ram_r [0:`COC_COLS-1]; // Per-column offsets.
    reg [1:0]            st_r;        // Calibration state.
    reg [1:0]            row_r;       // Dark row counter.
    reg [9:0]            acc_r [0:`COC_COLS-1]; // Dark-row sums per column.
    reg                  cal_prev_r;  // Last value of the cal bit.
    reg [3:0]            ram_q_r;     // Registered RAM read for pixels.
    reg [3:0]            rd_q_r;      // Value shown at the RAM port.
    reg [9:0]            sum_nxt;     // Accumulated sum for current column.
    reg [9:0]            avg;         // Four-row average, signed.
    reg [9:0]            neg_avg;     // Magnitude of a negative average.
    reg [3:0]            code_nxt;    // Averaged value clipped to a code.

    // Register decodes. Every access is a single-cycle strobe, so the
    // decode needs no memory of earlier cycles.
    wire wr_dc   = reg_wr_in && (reg_addr_in == `COC_ADDR_DC);
    wire wr_ctrl = reg_wr_in && (reg_addr_in == `COC_ADDR_CTRL);
    wire wr_ram  = reg_wr_in && (reg_addr_in == `COC_ADDR_RAM);
    wire cal_bit = ctrl_r[`COC_CTRL_CAL];
    wire in_col  = dark_col_in < `COC_COLS;
    // Software RAM writes are locked out while calibration owns the store,
    // so a stray write cannot overwrite a freshly measured column.
    wire sw_load = wr_ram && (st_r != ST_MEAS);

    // Global and control registers; the DC offset starts at zero so no
    // offset is applied until software asks for one.
    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dc_r   <= `COC_DC_RST;
            ctrl_r <= `COC_CTRL_RST;
        end else begin
            if (wr_dc) begin
                dc_r <= reg_wdata_in[`COC_DC_SIGN:0];
            end
            // Reserved control bits are kept and read back but do nothing.
            if (wr_ctrl) begin
                ctrl_r <= reg_wdata_in;
            end
        end
    end

    // Clip a dark-row average into the 4-bit sign-magnitude RAM code; the
    // stored step is two ADC codes, so the average is halved first.
    always @* begin
        sum_nxt = acc_r[dark_col_in] + {{2{dark_diff_in[7]}}, dark_diff_in};
        avg     = {{2{sum_nxt[9]}}, sum_nxt[9:2]};
        neg_avg = 10'h000 - avg;
        if (avg[9]) begin
            // Slice the magnitude to three bits so the sign bit survives.
            code_nxt = (neg_avg > `COC_CLIP_LIM) ? `COC_CODE_NEG_MAX :
                       {1'b1, neg_avg[3:1]};
        end else begin
            code_nxt = (avg > `COC_CLIP_LIM) ? `COC_CODE_POS_MAX :
                       {1'b0, avg[3:1]};
        end
    end

    // Calibration sequencer. Reset lands in measurement so the RAM is
    // filled without any command; a rising cal bit starts it again.
    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_r       <= ST_MEAS;
            row_r      <= 2'h0;
            cal_prev_r <= 1'b0;
        end else begin
            cal_prev_r <= cal_bit;
            case (st_r)
                ST_IDLE: begin
                    // Only a rising cal bit restarts; a bit left high does
                    // not retrigger, and a request made mid-run is dropped.
                    if (cal_bit && !cal_prev_r) begin
                        st_r  <= ST_MEAS;
                        row_r <= 2'h0;
                    end
                end
                ST_MEAS: begin
                    // A row ends when its last column arrives.
                    if (dark_valid_in && dark_col_in == `COC_LAST_COL) begin
                        row_r <= row_r + 2'h1;
                        if (row_r == `COC_DARK_LAST) begin
                            st_r <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    // One settling cycle lets the last RAM entry land before
                    // the busy flag drops.
                    st_r <= ST_IDLE;
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Accumulators and the offset store. Memories have no reset, which
    // keeps them in plain RAM; calibration overwrites every entry anyway.
    // Row zero seeds each sum, so no clear pass over the sums is needed.
    always @(posedge sys_clk_in) begin
        if (st_r == ST_MEAS && dark_valid_in && in_col) begin
            acc_r[dark_col_in] <= (row_r == 2'h0) ?
                {{2{dark_diff_in[7]}}, dark_diff_in} : sum_nxt;
            if (row_r == `COC_DARK_LAST) begin
                ram_r[dark_col_in] <= code_nxt;
            end
        end else if (sw_load) begin
            ram_r[ld_col_r] <= reg_wdata_in[`COC_RAM_SIGN:0];
        end
        // Both read ports are registered, which costs one cycle of latency
        // but lets the store map onto a plain synchronous RAM.
        ram_q_r <= ram_r[pix_col_in];
        rd_q_r  <= ram_r[ld_col_r];
    end

    // Load counter: cleared while cntr is set, else advanced per RAM write.
    // The clear is a level, so a controller that lost its place can hold
    // the bit while it recovers and start again at column 0.
    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ld_col_r <= {`COC_COL_W{1'b0}};
        end else if (ctrl_r[`COC_CTRL_CNTR]) begin
            ld_col_r <= {`COC_COL_W{1'b0}};
        end else if (sw_load) begin
            if (ld_col_r == `COC_LAST_COL) begin
                ld_col_r <= {`COC_COL_W{1'b0}};
            end else begin
                ld_col_r <= ld_col_r + 10'h001;
            end
        end
    end

    // Outputs. The global path is on from reset; per-column values are
    // used in its place only when the enable bit is set.
    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_rdata_out     <= 8'h00;
            col_offset_out    <= 11'h000;
            offset_enable_out <= 1'b1;
            cal_busy_out      <= 1'b1;
        end else begin
            offset_enable_out <= 1'b1;
            cal_busy_out      <= (st_r == ST_MEAS);
            if (ctrl_r[`COC_CTRL_ECE]) begin
                col_offset_out <= coc_doubled(ram_q_r[`COC_RAM_SIGN],
                    {2'h0, ram_q_r[`COC_RAM_MAG_HI:0]});
            end else begin
                col_offset_out <= coc_doubled(dc_r[`COC_DC_SIGN],
                    dc_r[`COC_DC_MAG_HI:0]);
            end
            // Read data is latched only on a read strobe and holds until
            // the next read; a RAM-port read shows the entry at the load
            // counter, one cycle behind the store.
            if (reg_rd_in) begin
                case (reg_addr_in)
                    `COC_ADDR_DC:   reg_rdata_out <= {2'h0, dc_r};
                    `COC_ADDR_CTRL: reg_rdata_out <= ctrl_r;
                    `COC_ADDR_RAM:  reg_rdata_out <= {4'h0, rd_q_r};
                    default:        reg_rdata_out <= 8'h00;
                endcase
            end
        end
    end

endmodule // coc_column_offset_calibration

// *** verification/coc_sva.sv ***
`timescale 1ns/1ps
`include "coc_defines.vh"
module coc_sva (
    // Clock and reset.
    input wire        sys_clk_in,
    input wire        nrst_in,
    // Register port.
    input wire        reg_wr_in,
    input wire        reg_rd_in,
    input wire [7:0]  reg_addr_in,
    input wire [7:0]  reg_wdata_in,
    input wire [7:0]  reg_rdata_out,
    // Pixel side.
    input wire [10:0] col_offset_out,
    input wire        offset_enable_out,
    input wire        cal_busy_out
);
    // Last calibration bit written, so a write that leaves the bit set is
    // not taken for a fresh request.
    reg cal_seen_r;
    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cal_seen_r <= 1'b0;
        end else if (reg_wr_in && reg_addr_in == `COC_ADDR_CTRL) begin
            cal_seen_r <= reg_wdata_in[`COC_CTRL_CAL];
        end
    end
    // Every check lives in the one clock domain.
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    a_enable_always_on: assert property (offset_enable_out)
        else $error("offset path disabled");
    a_unmapped_reads_zero: assert property (
        reg_rd_in && (reg_addr_in < `COC_ADDR_DC ||
        reg_addr_in > `COC_ADDR_RAM) |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (
        !reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data moved without read");
    a_dc_readback: assert property (
        (reg_wr_in && reg_addr_in == `COC_ADDR_DC)
        ##1 !(reg_wr_in && reg_addr_in == `COC_ADDR_DC)
        ##1 (reg_rd_in && reg_addr_in == `COC_ADDR_DC)
        |=> reg_rdata_out[5:0] == $past(reg_wdata_in[5:0], 3))
        else $error("dc offset readback wrong");
    a_ctrl_readback: assert property (
        (reg_wr_in && reg_addr_in == `COC_ADDR_CTRL)
        ##1 !(reg_wr_in && reg_addr_in == `COC_ADDR_CTRL)
        ##1 (reg_rd_in && reg_addr_in == `COC_ADDR_CTRL)
        |=> reg_rdata_out == $past(reg_wdata_in, 3))
        else $error("control readback wrong");
    a_offset_doubled: assert property (!col_offset_out[0] &&
        $signed(col_offset_out) <= $signed(11'h03E) &&
        $signed(col_offset_out) >= $signed(11'h7C2))
        else $error("offset odd or out of range");
    a_cal_at_start: assert property ($rose(nrst_in) |-> cal_busy_out)
        else $error("no calibration after reset");
    a_cal_on_cmd: assert property (
        reg_wr_in && reg_addr_in == `COC_ADDR_CTRL &&
        reg_wdata_in[`COC_CTRL_CAL] && !cal_seen_r && !cal_busy_out
        |-> ##[1:3] cal_busy_out)
        else $error("calibration not started");
endmodule // coc_sva
bind coc_column_offset_calibration coc_sva u_sva (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .col_offset_out(col_offset_out),
    .offset_enable_out(offset_enable_out), .cal_busy_out(cal_busy_out));

// *** verification/coc_ctrl_model.sv ***
`timescale 1ns/1ps
module coc_ctrl_model (
    // Clock and read data from the block.
    input  wire       clk_in,
    input  wire [7:0] rdata_in,
    // Strobes, address and data toward the block.
    output reg        wr_out,
    output reg        rd_out,
    output reg  [7:0] addr_out,
    output reg  [7:0] wdata_out
);
    // Idle bus parks on junk so stale values are never trusted.
    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = 8'hFF;
        wdata_out = 8'hFF;
    end
    // One write, held for exactly one sampling edge.
    task wr(input [7:0] a, input [7:0] d); begin
        @(posedge clk_in);
        wr_out <= 1'b1;
        addr_out <= a;
        wdata_out <= d;
        @(posedge clk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    end endtask
    // One read; data is taken a cycle after the strobe is seen.
    task rd(input [7:0] a, output [7:0] d); begin
        @(posedge clk_in);
        rd_out <= 1'b1;
        addr_out <= a;
        @(posedge clk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        @(posedge clk_in);
        #1 d = rdata_in;
    end endtask
endmodule // coc_ctrl_model

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`include "coc_defines.vh"
module testbench;
    reg sys_clk, nrst, dv;
    reg [9:0] dcol, pcol;
    reg [7:0] ddiff, v;
    wire wr, rd, oen, busy;
    wire [7:0] addr, wdata, rdata;
    wire [10:0] coff;
    integer n_fail, tests_run, i, r;
    coc_ctrl_model u_ctl (.clk_in(sys_clk), .rdata_in(rdata), .wr_out(wr),
        .rd_out(rd), .addr_out(addr), .wdata_out(wdata));
    coc_column_offset_calibration dut (.sys_clk_in(sys_clk), .nrst_in(nrst),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .dark_valid_in(dv),
        .dark_col_in(dcol), .dark_diff_in(ddiff), .pix_col_in(pcol),
        .col_offset_out(coff), .offset_enable_out(oen), .cal_busy_out(busy));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task chk(input [10:0] seen, input [10:0] exp); begin
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    end endtask
    task summarize; begin
        $display("mismatches %0d of %0d checks", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end endtask
    // Bounded wait for the busy flag; a stuck flag ends the run.
    task waitb(input b); begin
        for (i = 0; i < 100 && busy !== b; i = i + 1) begin
            @(posedge sys_clk);
            #1;
        end
        chk({10'h000, busy}, {10'h000, b});
        if (busy !== b)
            summarize;
    end endtask
    // Four full dark rows of one constant sample, then wait for the end.
    task feed(input [7:0] d); begin
        for (r = 0; r < `COC_DARK_ROWS; r = r + 1)
            for (i = 0; i < `COC_COLS; i = i + 1) begin
                @(posedge sys_clk);
                dv <= 1'b1;
                dcol <= i[9:0];
                ddiff <= d;
            end
        @(posedge sys_clk);
        dv <= 1'b0;
        waitb(1'b0);
    end endtask
    // Offset appears two cycles after the column is presented.
    task off(input [9:0] c, input [10:0] e); begin
        @(posedge sys_clk);
        pcol <= c;
        repeat (3) @(posedge sys_clk);
        #1 chk(coff, e);
    end endtask
    task t_reset; begin
        chk({10'h000, oen}, 11'h001);
        chk({10'h000, busy}, 11'h001);
        u_ctl.rd(`COC_ADDR_DC, v);
        chk({3'h0, v}, 11'h000);
        u_ctl.rd(`COC_ADDR_CTRL, v);
        chk({3'h0, v}, 11'h000);
        u_ctl.rd(8'h55, v);
        chk({3'h0, v}, 11'h000);
    end endtask
    task t_autocal; begin
        feed(8'hFA);
        u_ctl.wr(`COC_ADDR_CTRL, 8'h10);
        off(10'h005, 11'h7FA);
        off(`COC_LAST_COL, 11'h7FA);
    end endtask
    task t_dc; begin
        u_ctl.wr(`COC_ADDR_DC, 8'h25);
        u_ctl.rd(`COC_ADDR_DC, v);
        chk({5'h00, v[5:0]}, 11'h025);
        u_ctl.wr(`COC_ADDR_CTRL, 8'h00);
        off(10'h007, 11'h7F6);
    end endtask
    // Load the column store by hand, then write once more to wrap.
    task t_load; begin
        // A cut-off partial load leaves the counter at column 3.
        for (r = 0; r < 3; r = r + 1)
            u_ctl.wr(`COC_ADDR_RAM, 8'h07);
        u_ctl.wr(`COC_ADDR_CTRL, 8'h12);
        u_ctl.rd(`COC_ADDR_CTRL, v);
        chk({3'h0, v}, 11'h012);
        u_ctl.wr(`COC_ADDR_CTRL, 8'h10);
        for (r = 0; r < `COC_COLS; r = r + 1)
            u_ctl.wr(`COC_ADDR_RAM, {5'h14, r[2:0]});
        off(10'h000, 11'h000);
        off(10'h00A, 11'h004);
        off(`COC_LAST_COL, 11'h00E);
        u_ctl.wr(`COC_ADDR_RAM, 8'h0D);
        off(10'h000, 11'h7F6);
        off(10'h001, 11'h002);
        u_ctl.rd(`COC_ADDR_RAM, v);
        chk({3'h0, v}, 11'h001);
    end endtask
    task t_recal; begin
        u_ctl.wr(`COC_ADDR_CTRL, 8'h11);
        waitb(1'b1);
        feed(8'h04);
        u_ctl.wr(`COC_ADDR_CTRL, 8'h10);
        off(10'h000, 11'h004);
    end endtask
    initial begin
        n_fail = 0;
        tests_run = 0;
        nrst = 1'b0;
        dv = 1'b0;
        dcol = 10'h000;
        ddiff = 8'h00;
        pcol = 10'h000;
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset;
        t_autocal;
        t_dc;
        t_load;
        t_recal;
        summarize;
    end
endmodule // testbench
